//--- otps_seq.sv
// device side of the serial program/verify mode sequencer
`timescale 1ns/1ps
`include "otps_defs.svh"

// Behaviour
// - both straps low while clear rises: enter
// - first address after entry is fuse location
// - one increment moves fuse to address zero
// - increments step through user memory to top
// - past top, special area selected, no wrap
// - programmer clocks; data pin carries both ways
// - six command bits, lsb first, falling edge
// - data word 16 clocks, start/stop, lsb first
module otps_seq #(
  parameter bit LARGE = 1'b0
) (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      nrst,
  // programming pins
  input  wire logic                      master_clear_pin,
  input  wire logic                      entry_strap_low_a,
  input  wire logic                      entry_strap_low_b,
  input  wire logic                      serial_clock_pin,
  input  wire logic                      serial_data_pin_i,
  output logic                           serial_data_pin_o,
  output logic                           serial_data_pin_oe,
  // memory array side
  output logic                           prog_mode,
  output logic [`OTPS_PC_W-1:0]          pc,
  output logic                           special_sel,
  output logic [`OTPS_WORD_W-1:0]        load_word,
  output logic                           load_stb,
  input  wire logic [`OTPS_WORD_W-1:0]   read_word
);
  localparam logic [`OTPS_PC_W-1:0] TOP = LARGE ? `OTPS_TOP_LARGE : `OTPS_TOP_SMALL;

  // two-flop synchronisers for all pins
  logic [1:0] master_clear_pin_s, sa_s, sb_s, sck_s, sd_s;
  logic       sck_d1;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      master_clear_pin_s <= 2'b00;
      sa_s   <= 2'b00;
      sb_s   <= 2'b00;
      sck_s  <= 2'b00;
      sd_s   <= 2'b00;
      sck_d1 <= 1'b0;
    end else begin
      master_clear_pin_s <= {master_clear_pin_s[0], master_clear_pin};
      sa_s   <= {sa_s[0], entry_strap_low_a};
      sb_s   <= {sb_s[0], entry_strap_low_b};
      sck_s  <= {sck_s[0], serial_clock_pin};
      sd_s   <= {sd_s[0], serial_data_pin_i};
      sck_d1 <= sck_s[1];
    end
  end

  logic master_clear_pin_d1;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) master_clear_pin_d1 <= 1'b0;
    else       master_clear_pin_d1 <= master_clear_pin_s[1];
  end

  // entry needs a rising clear with both straps low; a clear already high
  // at power-up still enters if the straps are low, since the synchroniser resets low and sees it rise
  wire entry = master_clear_pin_s[1] && !master_clear_pin_d1 && !sa_s[1] && !sb_s[1];
  wire fall  = sck_d1 && !sck_s[1];
  wire rise  = !sck_d1 && sck_s[1];

  otps_pkg::otps_state_t st_q;
  logic [4:0]            bit_q;
  logic [15:0]           sh_q;
  logic [`OTPS_PC_W-1:0] pc_q;
  logic                  spec_q;

  // command word as it stands at the sixth falling edge, lsb shifted in first
  function automatic logic [`OTPS_CMD_W-1:0] cmd_code(input logic b, input logic [15:0] sh);
    cmd_code = {b, sh[15:11]};
  endfunction : cmd_code

  // mode, command and data framing
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q      <= otps_pkg::OTPS_OFF;
      bit_q     <= 5'h00;
      sh_q      <= 16'h0000;
      load_stb  <= 1'b0;
      load_word <= '0;
    end else begin
      load_stb <= 1'b0;
      if (!master_clear_pin_s[1]) begin
        st_q <= otps_pkg::OTPS_OFF;
      end else if (entry) begin
        st_q  <= otps_pkg::OTPS_CMD;
        bit_q <= 5'h00;
      end else begin
        case (st_q)
          otps_pkg::OTPS_CMD: if (fall) begin
            sh_q  <= {sd_s[1], sh_q[15:1]};
            bit_q <= bit_q + 5'h01;
            if (bit_q == 5'(`OTPS_CMD_W - 1)) begin
              bit_q <= 5'h00;
              case (cmd_code(sd_s[1], sh_q))
                `OTPS_CMD_LOAD: st_q <= otps_pkg::OTPS_LOAD;
                `OTPS_CMD_READ: begin
                  st_q <= otps_pkg::OTPS_READ;
                  sh_q <= {1'b0, read_word, 1'b0};
                end
                default: st_q <= otps_pkg::OTPS_CMD;
              endcase
            end
          end
          otps_pkg::OTPS_LOAD: if (fall) begin
            sh_q  <= {sd_s[1], sh_q[15:1]};
            bit_q <= bit_q + 5'h01;
            if (bit_q == 5'(`OTPS_DATA_BITS - 1)) begin
              bit_q     <= 5'h00;
              st_q      <= otps_pkg::OTPS_CMD;
              load_word <= sh_q[15:2];
              load_stb  <= 1'b1;
            end
          end
          otps_pkg::OTPS_READ: if (fall) begin
            sh_q  <= {1'b0, sh_q[15:1]};
            bit_q <= bit_q + 5'h01;
            if (bit_q == 5'(`OTPS_DATA_BITS - 1)) begin
              bit_q <= 5'h00;
              st_q  <= otps_pkg::OTPS_CMD;
            end
          end
          default: st_q <= otps_pkg::OTPS_OFF;
        endcase
      end
    end
  end

  wire incr_cmd = (st_q == otps_pkg::OTPS_CMD) && fall &&
                  (bit_q == 5'(`OTPS_CMD_W - 1)) &&
                  (cmd_code(sd_s[1], sh_q) == `OTPS_CMD_INCR);

  // program counter
  // pc keeps counting past top; special area is a separate select so that
  // the user range never wraps back onto address zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pc_q   <= `OTPS_PC_FUSE;
      spec_q <= 1'b0;
    end else if (!master_clear_pin_s[1] || entry) begin
      pc_q   <= `OTPS_PC_FUSE;
      spec_q <= 1'b0;
    end else if (incr_cmd) begin
      pc_q <= pc_q + 12'h001;
      if (pc_q == TOP) spec_q <= 1'b1;
    end
  end

  // data pin driven only between read start and stop
  // next bit leaves on the rise, so the programmer sees it settled at the fall
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      serial_data_pin_o  <= 1'b0;
      serial_data_pin_oe <= 1'b0;
    end else begin
      if (rise) serial_data_pin_o <= sh_q[0];
      serial_data_pin_oe <= (st_q == otps_pkg::OTPS_READ) && master_clear_pin_s[1];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prog_mode   <= 1'b0;
      pc          <= `OTPS_PC_FUSE;
      special_sel <= 1'b0;
    end else begin
      prog_mode   <= (st_q != otps_pkg::OTPS_OFF);
      pc          <= pc_q;
      special_sel <= spec_q;
    end
  end

  a_entry_fuse: assert property (@(posedge clock) disable iff (!nrst)
    entry |=> (pc_q == `OTPS_PC_FUSE) && !spec_q)
    else $error("entry did not select fuse");
  a_incr_zero: assert property (@(posedge clock) disable iff (!nrst)
    incr_cmd && pc_q == `OTPS_PC_FUSE && master_clear_pin_s[1] && !entry |=> pc_q == `OTPS_PC_USER0)
    else $error("fuse increment not zero");
  a_top_special: assert property (@(posedge clock) disable iff (!nrst)
    incr_cmd && pc_q == TOP && master_clear_pin_s[1] && !entry |=> spec_q)
    else $error("special area not selected");
  a_entry_mode: assert property (@(posedge clock) disable iff (!nrst)
    entry |=> st_q == otps_pkg::OTPS_CMD)
    else $error("mode not entered");
  a_oe_read: assert property (@(posedge clock) disable iff (!nrst)
    serial_data_pin_oe |-> $past(st_q) == otps_pkg::OTPS_READ)
    else $error("pin driven outside read");
  a_stb_pulse: assert property (@(posedge clock) disable iff (!nrst)
    load_stb |=> !load_stb)
    else $error("load strobe longer than one cycle");
  a_pc_hold: assert property (@(posedge clock) disable iff (!nrst)
    master_clear_pin_s[1] && !entry && !incr_cmd |=> pc_q == $past(pc_q))
    else $error("pc moved without increment");
  a_oe_mode: assert property (@(posedge clock) disable iff (!nrst)
    serial_data_pin_oe |-> prog_mode)
    else $error("pin driven outside program mode");
endmodule : otps_seq

//--- otps_defs.svh
// constants for the program/verify mode sequencer
`ifndef OTPS_DEFS_SVH
`define OTPS_DEFS_SVH
`define OTPS_PC_W        12
`define OTPS_PC_FUSE     12'hfff
`define OTPS_PC_USER0    12'h000
`define OTPS_TOP_SMALL   12'h1ff
`define OTPS_TOP_LARGE   12'h3ff
`define OTPS_CMD_W       6
`define OTPS_CMD_LOAD    6'h02
`define OTPS_CMD_READ    6'h04
`define OTPS_CMD_INCR    6'h06
`define OTPS_DATA_BITS   16
`define OTPS_WORD_W      14
`define OTPS_GAP_NS      1000
`define OTPS_CLK_NS      5
`define OTPS_GAP_CYC     ((`OTPS_GAP_NS + `OTPS_CLK_NS - 1) / `OTPS_CLK_NS)
`endif

//--- otps_pkg.sv
// types for the program/verify mode sequencer
package otps_pkg;
  typedef enum logic [1:0] {
    OTPS_OFF  = 2'b00,
    OTPS_CMD  = 2'b01,
    OTPS_LOAD = 2'b10,
    OTPS_READ = 2'b11
  } otps_state_t;
endpackage : otps_pkg

//--- otps_prog.sv
// behavioural programmer model driving the serial link
`timescale 1ns/1ps
`include "otps_defs.svh"

module otps_prog #(
  parameter int OVER_MULT = 11
) (
  // link pins
  output logic      serial_clock_pin,
  output logic      data_drv,
  input  wire logic data_in
);
  localparam int HALF_NS = 32;
  localparam int GAP_NS  = 1000;
  localparam int MAX_PULSES = 8;

  // clock idles low between frames
  initial begin
    serial_clock_pin = 1'b0;
    data_drv         = 1'b0;
  end

  // data changes on rise, device takes it on fall
  task automatic cyc(input logic b, output logic s);
    serial_clock_pin = 1'b1;
    data_drv         = b;
    #HALF_NS;
    s                = data_in;
    serial_clock_pin = 1'b0;
    #HALF_NS;
  endtask : cyc

  task automatic cmd(input logic [5:0] c);
    logic s;
    for (int i = 0; i < 6; i++) cyc(c[i], s);
    #GAP_NS;
  endtask : cmd

  task automatic load(input logic [13:0] w);
    logic s;
    cyc(1'b0, s);
    for (int i = 0; i < 14; i++) cyc(w[i], s);
    cyc(1'b0, s);
    #GAP_NS;
  endtask : load

  // released line: toggle every cycle so a stale value cannot pass
  task automatic read(output logic [13:0] w);
    logic s;
    cyc(~data_drv, s);
    for (int i = 0; i < 14; i++) begin
      cyc(~data_drv, s);
      w[i] = s;
    end
    cyc(~data_drv, s);
    #GAP_NS;
  endtask : read

  // pulse and read back until verified or the limit; then over-program only if verified
  task automatic program_word(input logic [13:0] w, output int pulses, output logic ok);
    logic [13:0] r;
    pulses = 0;
    ok     = 1'b0;
    while (!ok && pulses < MAX_PULSES) begin
      cmd(`OTPS_CMD_LOAD);
      load(w);
      cmd(`OTPS_CMD_READ);
      read(r);
      pulses++;
      ok = (r == w);
    end
    if (ok) begin
      for (int j = 0; j < OVER_MULT * pulses; j++) begin
        cmd(`OTPS_CMD_LOAD);
        load(w);
      end
    end
  endtask : program_word
endmodule : otps_prog

//--- tb_top.sv
// self-checking bench for the program/verify sequencer
`timescale 1ns/1ps
`include "otps_defs.svh"

module tb_top;
  logic                    clock, nrst, master_clear_pin, entry_strap_low_a, entry_strap_low_b;
  logic                    serial_clock_pin, data_drv, serial_data_pin_o, serial_data_pin_oe;
  logic                    prog_mode, special_sel, load_stb;
  logic [`OTPS_PC_W-1:0]   pc;
  logic [`OTPS_WORD_W-1:0] load_word, read_word, got, w;
  logic [`OTPS_PC_W-1:0]   pc_q[$];
  logic [`OTPS_WORD_W-1:0] ld_q[$];
  int                      mismatches, n_tests, seed, armed, pulses;
  logic                    ok, echo;
  wire logic               serial_data_pin_i = serial_data_pin_oe ? serial_data_pin_o : data_drv;

  otps_seq #(.LARGE(1'b0)) u_otps_seq (.clock, .nrst, .master_clear_pin, .entry_strap_low_a,
    .entry_strap_low_b, .serial_clock_pin, .serial_data_pin_i, .serial_data_pin_o,
    .serial_data_pin_oe, .prog_mode, .pc, .special_sel, .load_word, .load_stb, .read_word);
  otps_prog u_otps_prog (.serial_clock_pin, .data_drv, .data_in(serial_data_pin_i));

  always #2.5 clock = ~clock;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    if (mismatches == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  // any pc move without a note is a fault
  always @(pc) if (armed) check("pc", pc, pc_q.size() ? pc_q.pop_front() : 'x);
  // array model: while echo is on, a load lands in the word read back
  always @(negedge clock) if (load_stb === 1'b1) begin
    check("load_word", load_word, ld_q.size() ? ld_q.pop_front() : 'x);
    if (echo) read_word = load_word;
  end

  initial begin
    {clock, nrst, master_clear_pin, entry_strap_low_b, read_word, armed} = '0;
    entry_strap_low_a = 1'b1;
    echo              = 1'b0;
    {mismatches, n_tests, seed} = {32'd0, 32'd0, 32'd8};
    repeat (12) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    master_clear_pin = 1'b1;
    repeat (20) @(negedge clock);
    check("prog_mode", prog_mode, 1'b0);
    {master_clear_pin, entry_strap_low_a} = 2'b00;
    repeat (4) @(negedge clock);
    master_clear_pin = 1'b1;
    repeat (20) @(negedge clock);
    check("prog_mode", prog_mode, 1'b1);
    check("pc", pc, `OTPS_PC_FUSE);
    armed = 1;
    for (int k = 0; k < 3; k++) begin
      @(negedge clock);
      w         = 14'($random(seed));
      read_word = 14'($random(seed));
      ld_q.push_back(w);
      u_otps_prog.cmd(`OTPS_CMD_LOAD);
      u_otps_prog.load(w);
      u_otps_prog.cmd(`OTPS_CMD_READ);
      u_otps_prog.read(got);
      check("read_word", got, read_word);
    end
    echo = 1'b1;
    w    = 14'($random(seed));
    repeat (12) ld_q.push_back(w); // one pulse plus eleven over-programming loads
    u_otps_prog.program_word(w, pulses, ok);
    check("verify_ok", ok, 1'b1);
    check("pulses", pulses, 16'h0001);
    echo = 1'b0;
    u_otps_prog.cmd(`OTPS_CMD_READ);
    u_otps_prog.read(got);
    check("final_verify", got, w);
    for (int i = 0; i <= `OTPS_TOP_SMALL + 1; i++) begin
      pc_q.push_back(12'(i));
      u_otps_prog.cmd(`OTPS_CMD_INCR);
      if (i == `OTPS_TOP_SMALL) check("special_sel", special_sel, 1'b0);
    end
    check("special_sel", special_sel, 1'b1);
    u_otps_prog.cmd(6'h3f);
    check("special_sel", special_sel, 1'b1);
    end_of_test();
  end

  // about 780 us of traffic expected
  initial begin
    #900000;
    mismatches++;
    end_of_test();
  end
endmodule : tb_top
